// File: verilog/aocs_top.sv
// offset calibration sequencer for the serial converter
`timescale 1ns/1ps
module aocs_top import aocs_pkg::*; (
  input wire logic clk_sys, // 20 MHz system clock
  input wire logic resetn, // power-up reset, active low
  input wire logic cs_n_pin, // frame select from host, active low
  input wire logic sclk_pin, // serial clock from host
  input wire logic [RES_W-1:0] raw_result, // uncorrected conversion result
  input wire logic [RES_W-1:0] offset_measured, // offset measured by calibration
  output logic serial_result_out, // serial data value
  output logic serial_result_oe_n, // serial data enable, low drives
  output logic inputs_connected, // analog inputs to sampling stage
  output logic cal_busy, // calibration in progress
  output logic cal_valid // store holds a completed calibration
);
  // ----------------------------------------------------------------
  // reset and pin synchronisation
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n_q;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  logic cs_n_s;
  logic sclk_s;
  aocs_sync u_cs (.clk_sys(clk_sys), .rst_n(rst_n_q), .din(cs_n_pin), .dout(cs_n_s));
  aocs_sync u_sck (.clk_sys(clk_sys), .rst_n(rst_n_q), .din(sclk_pin), .dout(sclk_s));

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cs_n;
    logic sclk;
    aocs_mode_e mode;
    logic pup_done;
    logic [CNT_W-1:0] edges;
    logic [RES_W-1:0] offset;
    logic have_cal;
    logic [RES_W-1:0] shreg;
    logic dout;
    logic oe_n;
    logic cal;
  } aocs_state_s;

  aocs_state_s st_q;
  aocs_state_s st_d;

  function automatic logic [RES_W-1:0] apply_offset(input logic [RES_W-1:0] raw, input logic [RES_W-1:0] off);
    logic [RES_W:0] diff;
    diff = {1'b0, raw} - {1'b0, off};
    apply_offset = diff[RES_W] ? '0 : diff[RES_W-1:0];
  endfunction

  logic cs_fall;
  logic cs_rise;
  logic sck_fall;
  assign cs_fall = st_q.cs_n & ~cs_n_s;
  assign cs_rise = ~st_q.cs_n & cs_n_s;
  assign sck_fall = st_q.sclk & ~sclk_s & ~cs_n_s;

  always_comb begin
    logic [CNT_W-1:0] nxt;
    nxt = (st_q.edges == CNT_MAX) ? CNT_MAX : st_q.edges + 6'h01;
    st_d = st_q;
    st_d.cs_n = cs_n_s;
    st_d.sclk = sclk_s;
    if (cs_fall) begin
      st_d.edges = '0;
      st_d.oe_n = 1'b0;
      st_d.dout = 1'b0;
      if (!st_q.pup_done) begin
        st_d.mode = AOCS_PUP;
        st_d.cal = 1'b1;
        st_d.pup_done = 1'b1; // a cut power-up frame is not retried
      end else begin
        st_d.mode = AOCS_NORM;
        st_d.shreg = st_q.have_cal ? apply_offset(raw_result, st_q.offset) : raw_result;
      end
    end else if (cs_rise) begin
      st_d.edges = '0;
      st_d.oe_n = 1'b1;
      st_d.dout = 1'b0;
      st_d.cal = 1'b0;
      st_d.mode = AOCS_IDLE;
    end else if (sck_fall && st_q.mode != AOCS_IDLE) begin
      st_d.edges = nxt;
      unique case (st_q.mode)
        AOCS_PUP: begin
          st_d.dout = 1'b0;
          if (nxt == PUP_CAL_EDGES) begin
            st_d.offset = offset_measured;
            st_d.have_cal = 1'b1;
            st_d.cal = 1'b0;
          end
        end
        AOCS_NORM: begin
          if (nxt == 6'h01) begin
            st_d.dout = 1'b0;
          end else if (nxt < DATA_END_EDGE) begin
            st_d.dout = st_q.shreg[RES_W-1];
            st_d.shreg = {st_q.shreg[RES_W-2:0], 1'b0};
          end else begin
            st_d.dout = 1'b0;
          end
          if (nxt == NRM_CAL_START) begin
            st_d.cal = 1'b1;
          end
          if (nxt == NRM_CAL_EDGES) begin
            st_d.offset = offset_measured;
            st_d.have_cal = 1'b1;
            st_d.cal = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q <= '{cs_n: 1'b1, sclk: 1'b1, mode: AOCS_IDLE, pup_done: 1'b0, edges: '0,
                offset: OFFSET_RESET, have_cal: 1'b0, shreg: '0, dout: 1'b0,
                oe_n: 1'b1, cal: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign serial_result_out = st_q.dout;
  assign serial_result_oe_n = st_q.oe_n;
  assign inputs_connected = ~st_q.cal;
  assign cal_busy = st_q.cal;
  assign cal_valid = st_q.have_cal;

  // ----------------------------------------------------------------
  // assertions: isolation and correction store
  // ----------------------------------------------------------------
  a_inputs_isolated: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    cal_busy |-> !inputs_connected)
    else $error("inputs connected during calibration");
  a_store_reset: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    !st_q.have_cal |-> st_q.offset == OFFSET_RESET)
    else $error("store not zero before calibration");
  a_pup_commit: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    $changed(st_q.offset) |-> (st_q.mode == AOCS_PUP && st_q.edges == PUP_CAL_EDGES) ||
      (st_q.mode == AOCS_NORM && st_q.edges == NRM_CAL_EDGES))
    else $error("store changed off threshold");
  a_cut_keeps_store: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    cs_rise && cal_busy |=> !cal_busy && $stable(st_q.offset))
    else $error("cut calibration touched the store");

  // ----------------------------------------------------------------
  // assertions: power-up frame
  // ----------------------------------------------------------------
  a_pup_cal_start: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    cs_fall && !st_q.pup_done |=> cal_busy && st_q.mode == AOCS_PUP)
    else $error("power-up calibration not started");
  a_pup_out_low: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    st_q.mode == AOCS_PUP |-> !serial_result_out)
    else $error("output high in power-up frame");
  a_pup_store_load: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    st_q.mode == AOCS_PUP && sck_fall && st_q.edges == PUP_CAL_EDGES - 6'h01 |=>
      cal_valid && !cal_busy && st_q.offset == $past(offset_measured))
    else $error("power-up calibration not committed at its threshold");

  // ----------------------------------------------------------------
  // assertions: normal frame
  // ----------------------------------------------------------------
  a_norm_commit: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    $rose(st_q.have_cal) |-> st_q.edges >= PUP_CAL_EDGES)
    else $error("calibration committed early");
  a_cal_window: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    st_q.mode == AOCS_NORM && cal_busy |-> st_q.edges >= NRM_CAL_START && st_q.edges < NRM_CAL_EDGES)
    else $error("normal calibration outside 17..31");
  a_norm_cal_start: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    st_q.mode == AOCS_NORM && sck_fall && st_q.edges == NRM_CAL_START - 6'h01 |=> cal_busy)
    else $error("normal calibration not started");
  a_norm_store_load: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    st_q.mode == AOCS_NORM && sck_fall && st_q.edges == NRM_CAL_EDGES - 6'h01 |=>
      cal_valid && !cal_busy && st_q.offset == $past(offset_measured))
    else $error("normal calibration not committed at its threshold");
  a_data_bits: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    st_q.mode == AOCS_NORM && sck_fall && st_q.edges != '0 && st_q.edges < DATA_END_EDGE - 6'h01 |=>
      serial_result_out == $past(st_q.shreg[RES_W-1]))
    else $error("data bit not taken from the result");
  a_tail_low: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    st_q.mode == AOCS_NORM && st_q.edges >= DATA_END_EDGE |-> !serial_result_out)
    else $error("tail not low");

  // ----------------------------------------------------------------
  // assertions: frame boundaries and edge count
  // ----------------------------------------------------------------
  a_frame_start: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    cs_fall |=> !serial_result_oe_n && !serial_result_out)
    else $error("frame start not driving a zero");
  a_frame_drive: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    st_q.mode != AOCS_IDLE |-> !serial_result_oe_n)
    else $error("output released inside a frame");
  a_release_hiz: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    cs_rise |=> serial_result_oe_n)
    else $error("output not released at frame end");
  a_count_clear: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    cs_rise |=> st_q.edges == '0)
    else $error("edge count not cleared");
  a_count_hold: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    sck_fall && st_q.edges == CNT_MAX |=> st_q.edges == CNT_MAX)
    else $error("edge count wrapped");

  // ----------------------------------------------------------------
  // cover points
  // ----------------------------------------------------------------
  c_pup_done: cover property (@(posedge clk_sys) disable iff (!rst_n_q) $rose(cal_valid));
  c_norm_cal: cover property (@(posedge clk_sys) disable iff (!rst_n_q)
    st_q.mode == AOCS_NORM && st_q.edges == NRM_CAL_EDGES);
  c_short_frame: cover property (@(posedge clk_sys) disable iff (!rst_n_q)
    cs_rise && st_q.mode == AOCS_PUP && st_q.edges < PUP_CAL_EDGES);
  c_cut_norm_cal: cover property (@(posedge clk_sys) disable iff (!rst_n_q)
    cs_rise && st_q.mode == AOCS_NORM && cal_busy);
  c_corrected_frame: cover property (@(posedge clk_sys) disable iff (!rst_n_q)
    cs_fall && st_q.pup_done && st_q.have_cal);
endmodule // aocs_top

// File: verilog/aocs_pkg.sv
// constants and types of the offset calibration sequencer
// Behaviour
// - while calibrating, both analog inputs stay disconnected from the sampling stage
// - correction store is internal; no serial access reads or writes it
// - power-up reset clears the correction store to zero
// - first frame after power-up starts calibration; 16 falling edges complete it
// - serial output held low for the whole power-up calibration frame
// - power-up frame shorter than 16 edges leaves the store unchanged
// - conversions after calibration are corrected by the store and shifted out
// - normal frame with 32 or more falling edges performs calibration
// - first 14 clocks of a normal frame convert and shift out the sample
// - normal calibration starts at edge 17 and finishes at edge 32
// - output low from edge 14 on; released to high impedance at frame end
// - normal frame shorter than 32 edges leaves the store unchanged
// - frame begins at select falling edge, ends at select rising edge
// - leading zero at frame start, another zero, then 12-bit straight binary
package aocs_pkg;
  localparam int RES_W = 12;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] PUP_CAL_EDGES = 6'h10;
  localparam logic [CNT_W-1:0] NRM_CAL_START = 6'h11;
  localparam logic [CNT_W-1:0] NRM_CAL_EDGES = 6'h20;
  localparam logic [CNT_W-1:0] DATA_END_EDGE = 6'h0e;
  localparam logic [CNT_W-1:0] CNT_MAX = 6'h3f;
  localparam logic [RES_W-1:0] OFFSET_RESET = 12'h000;
  localparam int ACQ_NS = 90;
  localparam int CLK_NS = 50;
  localparam int ACQ_CYCLES = (ACQ_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [1:0] {
    AOCS_IDLE = 2'b00,
    AOCS_PUP = 2'b01,
    AOCS_NORM = 2'b10
  } aocs_mode_e;
endpackage

// File: verilog/aocs_sync.sv
// two-flop synchroniser for the pin inputs
`timescale 1ns/1ps
module aocs_sync (
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // synchronised reset, active low
  input wire logic din, // asynchronous pin
  output logic dout // synchronised copy
);
  logic meta_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b1;
      dout <= 1'b1;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule // aocs_sync

// File: testbench/aocs_host_model.sv
// host model that frames select and serial clock and captures the data bits
`timescale 1ns/1ps
module aocs_host_model (
  input wire logic clk_sys, // system clock
  input wire logic serial_result_out, // data from device
  input wire logic serial_result_oe_n, // device drive enable
  input wire logic cal_busy, // calibration flag
  input wire logic inputs_connected, // analog switch state
  output logic cs_n_pin, // frame select
  output logic sclk_pin // serial clock, idle high
);
  logic [63:0] bits;
  logic busy_seen;
  logic bad_seen;
  initial begin
    cs_n_pin = 1'b1;
    sclk_pin = 1'b1;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
  task automatic look(input int i);
    bits[i] = serial_result_out;
    if (cal_busy === 1'b1) busy_seen = 1'b1;
    if (serial_result_oe_n !== 1'b0 || inputs_connected !== ~cal_busy) bad_seen = 1'b1;
  endtask
  // one frame with n falling serial clock edges, 400 ns period
  task automatic frame(input int n);
    bits = '0;
    busy_seen = 1'b0;
    bad_seen = 1'b0;
    wait_clk(1);
    cs_n_pin = 1'b0;
    wait_clk(8);
    look(0);
    for (int i = 1; i <= n; i++) begin
      sclk_pin = 1'b0;
      wait_clk(4);
      sclk_pin = 1'b1;
      wait_clk(4);
      look(i);
    end
    cs_n_pin = 1'b1;
    wait_clk(8);
  endtask
endmodule // aocs_host_model

// File: testbench/tb_top.sv
// self-checking bench for the offset calibration sequencer
`timescale 1ns/1ps
module tb_top import aocs_pkg::*; ;
  logic clk_sys, resetn, cs_n_pin, sclk_pin, out, oe_n, conn, busy, valid;
  logic [RES_W-1:0] raw_result, offset_measured;
  int n_errors, n_checks, store_m, raw, off, corr;
  bit valid_m, first_m;
  logic [63:0] exp;
  int len_t[10] = '{15, 14, 31, 32, 20, 16, 16, 33, 2, 17};
  bit rst_t[10] = '{1, 0, 0, 0, 0, 1, 0, 0, 0, 0};
  aocs_top dut (.clk_sys(clk_sys), .resetn(resetn), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin),
    .raw_result(raw_result), .offset_measured(offset_measured), .serial_result_out(out),
    .serial_result_oe_n(oe_n), .inputs_connected(conn), .cal_busy(busy), .cal_valid(valid));
  aocs_host_model host (.clk_sys(clk_sys), .serial_result_out(out), .serial_result_oe_n(oe_n),
    .cal_busy(busy), .inputs_connected(conn), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] want);
    n_checks++;
    if (seen !== want) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, want, seen);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #(40000 * 50);
    n_errors++;
    final_report;
  end
  initial begin
    resetn = 1'b0;
    raw_result = '0;
    offset_measured = '0;
    void'($urandom(71915));
    for (int t = 0; t < 10; t++) begin
      if (rst_t[t]) begin
        resetn = 1'b0;
        host.wait_clk(16);
        resetn = 1'b1;
        host.wait_clk(6);
        store_m = 0;
        valid_m = 0;
        first_m = 1;
        check("valid_after_reset", valid, 0);
        check("oe_after_reset", oe_n, 1);
        check("busy_after_reset", busy, 0);
        check("inputs_after_reset", conn, 1);
      end
      raw = (t == 4) ? 0 : $urandom % 4096;
      off = $urandom % 256;
      raw_result = raw[RES_W-1:0];
      offset_measured = off[RES_W-1:0];
      corr = !valid_m ? raw : (raw > store_m ? raw - store_m : 0);
      exp = '0;
      for (int k = 0; k < 12; k++) begin
        if (!first_m && len_t[t] >= 2 + k) exp[2 + k] = corr[11 - k];
      end
      host.frame(len_t[t]);
      check("frame_bits", host.bits, exp);
      check("busy_seen", host.busy_seen, first_m || len_t[t] >= 17);
      check("switch_or_drive", host.bad_seen, 0);
      check("oe_released", oe_n, 1);
      check("inputs_after_frame", conn, 1);
      check("busy_after_frame", busy, 0);
      if (len_t[t] >= (first_m ? 16 : 32)) begin
        store_m = off;
        valid_m = 1;
      end
      first_m = 0;
      check("cal_valid", valid, valid_m);
      $display("test %0d edges %0d done", t, len_t[t]);
    end
    final_report;
  end
endmodule // tb_top
